// *** hw/scrc_clk_div.sv ***
`timescale 1ns/100ps
`include "scrc_defs.svh"

module scrc_clk_div
    import scrc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // Divide count, zero stops the ticks
    input  wire logic [3:0] div_in,
    // One-cycle tick every div_in cycles
    output logic            tick_out
);

    logic [3:0] cnt_q;

    // Compare with >= so a smaller divisor taken mid-count recovers at once
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cnt_q    <= 4'h0;
            tick_out <= 1'b0;
        end
        else if (div_in == 4'h0)
        begin
            cnt_q    <= 4'h0;
            tick_out <= 1'b0;
        end
        else if (cnt_q >= div_in - 4'h1)
        begin
            cnt_q    <= 4'h0;
            tick_out <= 1'b1;
        end
        else
        begin
            cnt_q    <= cnt_q + 4'h1;
            tick_out <= 1'b0;
        end
    end

endmodule : scrc_clk_div

// *** hw/scrc_defs.svh ***
`ifndef SCRC_DEFS_SVH
`define SCRC_DEFS_SVH

// Reset configuration word layout (low word)
`define SCRC_RCW_W        32
`define SCRC_DIVBIT_POS   31
`define SCRC_SYSTEM_PLL_MULTIPLIER_MSB     27
`define SCRC_SYSTEM_PLL_MULTIPLIER_LSB     24
`define SCRC_CPLL_MSB     22
`define SCRC_CPLL_LSB     16
// Hard-coded option: multiplier 4, core 2:1, VCO divider 4
`define SCRC_RCW_HARD     32'h0424_0000

// Core PLL field sub-positions inside the 7-bit field
`define SCRC_VCO_MSB      6
`define SCRC_VCO_LSB      5
`define SCRC_MUL_MSB      4
`define SCRC_MUL_LSB      1
`define SCRC_HALF_POS     0

// Core PLL encodings
`define SCRC_VCO_SEL2     2'h0
`define SCRC_VCO_SEL4     2'h1
`define SCRC_VCO_SEL8     2'h2
`define SCRC_MUL_1        4'h1
`define SCRC_MUL_2        4'h2
`define SCRC_MUL_3        4'h3
`define SCRC_MUL_4        4'h4
`define SCRC_VCO_DIV2     4'h2
`define SCRC_VCO_DIV4     4'h4
`define SCRC_VCO_DIV8     4'h8

// Core VCO window in kHz (800 MHz to 1600 MHz)
`define SCRC_VCO_MIN_KHZ  32'h000C_3500
`define SCRC_VCO_MAX_KHZ  32'h0018_6A00

// Unit ratio codes, equal to the divide count they select
`define SCRC_R_OFF        2'h0
`define SCRC_R_FULL       2'h1
`define SCRC_R_HALF       2'h2
`define SCRC_R_THIRD      2'h3
`define SCRC_UNIT_RST     2'h3
`define SCRC_PCI_RST      1'h1

// Local bus divider field reset and sizes
`define SCRC_LBDIV_RST    4'h2
`define SCRC_NUM_DIV      6
`define SCRC_LB_IDX       5
`define SCRC_PCI_IDX      4
`define SCRC_SETTLE       2'h3

`endif

// *** hw/scrc_pkg.sv ***
`include "scrc_defs.svh"

package scrc_pkg;

    // Clock ratio choice of a configurable unit
    typedef enum logic [1:0] {
        SCRC_OFF   = `SCRC_R_OFF,
        SCRC_FULL  = `SCRC_R_FULL,
        SCRC_HALF  = `SCRC_R_HALF,
        SCRC_THIRD = `SCRC_R_THIRD
    } scrc_ratio_t;

    // Per-unit clock settings as software sees them
    typedef struct packed {
        scrc_ratio_t eth;
        scrc_ratio_t sdhc;
        scrc_ratio_t sec;
        scrc_ratio_t usb;
        logic        pci_on;
    } scrc_unit_cfg_t;

    // Fields of the core PLL field after decode
    typedef struct packed {
        logic [3:0] ratio_x2;
        logic [3:0] vco_div;
        logic       err;
    } scrc_core_t;

    typedef logic [31:0] scrc_freq_t;

endpackage : scrc_pkg

// *** hw/scrc_top.sv ***
`timescale 1ns/100ps
`include "scrc_defs.svh"

module scrc_top
    import scrc_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    // Reset configuration straps (pins)
    input  wire logic [31:0]          reset_config_word_low_in,
    input  wire logic                 hard_cfg_sel_in,
    input  wire logic                 pci_host_mode_in,
    input  wire logic [23:0]          primary_clock_input_khz_in,
    input  wire logic [23:0]          pci_sync_khz_in,
    // Software unit ratio and local bus settings
    input  wire logic                 unit_cfg_wr_in,
    input  wire scrc_unit_cfg_t       unit_cfg_in,
    input  wire logic                 lb_ratio_wr_in,
    input  wire logic [3:0]           local_bus_divide_field_in,
    // Derived frequencies and core PLL decode
    output scrc_freq_t                csb_freq_khz_out,
    output scrc_freq_t                core_freq_khz_out,
    output logic [3:0]                core_ratio_x2_out,
    output logic [3:0]                vco_div_out,
    output logic                      core_cfg_err_out,
    output logic                      vco_range_err_out,
    output logic                      cfg_ready_out,
    // Generated clocks and unit enables
    output logic                      memory_bus_clock_out,
    output logic                      memory_bus_clock_n_out,
    output logic [2:0]                local_bus_clock_outputs,
    output logic [4:0]                unit_clk_en_out,
    // Current software settings read back
    output scrc_unit_cfg_t            unit_cfg_out,
    output logic [3:0]                local_bus_clock_ratio_reg_out
);

    typedef enum logic [1:0] {ST_SETTLE, ST_LOAD, ST_RUN} scrc_state_t;

    scrc_state_t     state_q;
    logic [1:0]      settle_q;
    logic [31:0]     rcw_s1_q, rcw_s2_q;
    logic            hard_s1_q, hard_s2_q, host_s1_q, host_s2_q;
    logic [23:0]     primary_clock_input_s1_q, primary_clock_input_s2_q, pci_s1_q, pci_s2_q;
    logic [31:0]     rcw_q;
    logic            host_q;
    logic [23:0]     base_q;
    logic [6:0]      cpll;
    logic [3:0]      system_pll_multiplier;
    logic            div_bit;
    scrc_core_t      core;
    scrc_freq_t      csb_d, core_d, vco_f;
    logic [3:0]      div_sel [`SCRC_NUM_DIV];
    logic [`SCRC_NUM_DIV-1:0] ticks;

    // Two-flop synchronisers for every strap and pin frequency
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rcw_s1_q   <= 32'h0000_0000;
            rcw_s2_q   <= 32'h0000_0000;
            hard_s1_q  <= 1'b0;
            hard_s2_q  <= 1'b0;
            host_s1_q  <= 1'b0;
            host_s2_q  <= 1'b0;
            primary_clock_input_s1_q <= 24'h00_0000;
            primary_clock_input_s2_q <= 24'h00_0000;
            pci_s1_q   <= 24'h00_0000;
            pci_s2_q   <= 24'h00_0000;
        end
        else
        begin
            rcw_s1_q   <= reset_config_word_low_in;
            rcw_s2_q   <= rcw_s1_q;
            hard_s1_q  <= hard_cfg_sel_in;
            hard_s2_q  <= hard_s1_q;
            host_s1_q  <= pci_host_mode_in;
            host_s2_q  <= host_s1_q;
            primary_clock_input_s1_q <= primary_clock_input_khz_in;
            primary_clock_input_s2_q <= primary_clock_input_s1_q;
            pci_s1_q   <= pci_sync_khz_in;
            pci_s2_q   <= pci_s1_q;
        end
    end

    // Reset word is caught once after release, when the synchronisers are full
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_q  <= ST_SETTLE;
            settle_q <= 2'h0;
            rcw_q    <= 32'h0000_0000;
            host_q   <= 1'b0;
            base_q   <= 24'h00_0000;
        end
        else
        begin
            case (state_q)
                ST_SETTLE:
                begin
                    settle_q <= settle_q + 2'h1;
                    if (settle_q == `SCRC_SETTLE)
                        state_q <= ST_LOAD;
                end
                ST_LOAD:
                begin
                    rcw_q   <= hard_s2_q ? `SCRC_RCW_HARD : rcw_s2_q;
                    host_q  <= host_s2_q;
                    base_q  <= host_s2_q ? pci_s2_q : primary_clock_input_s2_q;
                    state_q <= ST_RUN;
                end
                ST_RUN:
                    state_q <= ST_RUN;
                default:
                    state_q <= ST_SETTLE;
            endcase
        end
    end

    assign cpll    = rcw_q[`SCRC_CPLL_MSB:`SCRC_CPLL_LSB];
    assign system_pll_multiplier    = rcw_q[`SCRC_SYSTEM_PLL_MULTIPLIER_MSB:`SCRC_SYSTEM_PLL_MULTIPLIER_LSB];
    assign div_bit = rcw_q[`SCRC_DIVBIT_POS];

    // core ratio decode, VCO divider decode, reserved codes
    always_comb
    begin
        core.ratio_x2 = 4'h0;
        core.vco_div  = 4'h0;
        core.err      = 1'b0;
        case ({cpll[`SCRC_MUL_MSB:`SCRC_MUL_LSB], cpll[`SCRC_HALF_POS]})
            {`SCRC_MUL_1, 1'b1}: core.ratio_x2 = 4'h3;
            {`SCRC_MUL_2, 1'b0}: core.ratio_x2 = 4'h4;
            {`SCRC_MUL_2, 1'b1}: core.ratio_x2 = 4'h5;
            {`SCRC_MUL_3, 1'b0}: core.ratio_x2 = 4'h6;
            {`SCRC_MUL_3, 1'b1}: core.ratio_x2 = 4'h7;
            {`SCRC_MUL_4, 1'b0}: core.ratio_x2 = 4'h8;
            default:             core.err      = 1'b1;
        endcase
        case (cpll[`SCRC_VCO_MSB:`SCRC_VCO_LSB])
            `SCRC_VCO_SEL2: core.vco_div = `SCRC_VCO_DIV2;
            `SCRC_VCO_SEL4: core.vco_div = `SCRC_VCO_DIV4;
            `SCRC_VCO_SEL8: core.vco_div = `SCRC_VCO_DIV8;
            default:        core.err     = 1'b1;
        endcase
        // 1.5:1 has no divide-by-2 setting
        if (core.ratio_x2 == 4'h3 && cpll[`SCRC_VCO_MSB:`SCRC_VCO_LSB] == `SCRC_VCO_SEL2)
            core.err = 1'b1;
    end

    // bus clock product; core clock is bus clock times ratio
    assign csb_d  = 32'(base_q) * 32'({1'b0, div_bit} + 2'h1) * 32'(system_pll_multiplier);
    assign core_d = 32'((64'(csb_d) * 64'(core.ratio_x2)) >> 1);
    assign vco_f  = 32'(64'(core_d) * 64'(core.vco_div));

    // Frequency and decode results, valid once the word is latched
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            csb_freq_khz_out  <= 32'h0000_0000;
            core_freq_khz_out <= 32'h0000_0000;
            core_ratio_x2_out <= 4'h0;
            vco_div_out       <= 4'h0;
            core_cfg_err_out  <= 1'b0;
            vco_range_err_out <= 1'b0;
            cfg_ready_out     <= 1'b0;
        end
        else if (state_q == ST_RUN)
        begin
            csb_freq_khz_out  <= csb_d;
            core_freq_khz_out <= core.err ? 32'h0000_0000 : core_d;
            core_ratio_x2_out <= core.ratio_x2;
            vco_div_out       <= core.vco_div;
            core_cfg_err_out  <= core.err;
            // report a VCO outside its window, the strap source must avoid it
            vco_range_err_out <= !core.err && (vco_f < `SCRC_VCO_MIN_KHZ || vco_f > `SCRC_VCO_MAX_KHZ);
            cfg_ready_out     <= 1'b1;
        end
    end

    // software unit settings, default third, PCI defaults on
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            unit_cfg_out.eth    <= scrc_ratio_t'(`SCRC_UNIT_RST);
            unit_cfg_out.sdhc   <= scrc_ratio_t'(`SCRC_UNIT_RST);
            unit_cfg_out.sec    <= scrc_ratio_t'(`SCRC_UNIT_RST);
            unit_cfg_out.usb    <= scrc_ratio_t'(`SCRC_UNIT_RST);
            unit_cfg_out.pci_on <= `SCRC_PCI_RST;
        end
        else if (unit_cfg_wr_in)
            unit_cfg_out <= unit_cfg_in;
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            local_bus_clock_ratio_reg_out <= `SCRC_LBDIV_RST;
        else if (lb_ratio_wr_in)
            local_bus_clock_ratio_reg_out <= local_bus_divide_field_in;
    end

    // Divide counts: unit codes equal their divisor, PCI is full or off
    assign div_sel[0]             = {2'h0, unit_cfg_out.eth};
    assign div_sel[1]             = {2'h0, unit_cfg_out.sdhc};
    assign div_sel[2]             = {2'h0, unit_cfg_out.sec};
    assign div_sel[3]             = {2'h0, unit_cfg_out.usb};
    assign div_sel[`SCRC_PCI_IDX] = {3'h0, unit_cfg_out.pci_on};
    // Toggle per tick, so half the field gives the full divide
    assign div_sel[`SCRC_LB_IDX]  = local_bus_clock_ratio_reg_out >> 1;

    // one divider per unit plus the local bus
    genvar gi;
    generate
        for (gi = 0; gi < `SCRC_NUM_DIV; gi++)
        begin : g_div
            scrc_clk_div u_div (
                .clk_in   (clk_in),
                .reset_in (reset_in),
                .div_in   (div_sel[gi]),
                .tick_out (ticks[gi])
            );
        end
    endgenerate

    // Unit enables come straight from the divider flops
    assign unit_clk_en_out = ticks[`SCRC_PCI_IDX:0];

    // memory pair toggles each cycle; local bus toggles per tick
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            memory_bus_clock_out    <= 1'b0;
            memory_bus_clock_n_out  <= 1'b1;
            local_bus_clock_outputs <= 3'h0;
        end
        else
        begin
            memory_bus_clock_out   <= ~memory_bus_clock_out;
            memory_bus_clock_n_out <= memory_bus_clock_out;
            if (ticks[`SCRC_LB_IDX])
                local_bus_clock_outputs <= ~local_bus_clock_outputs;
        end
    end

    // Checks next to the logic they guard
    csb_formula_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $past(state_q == ST_RUN) |-> csb_freq_khz_out == $past(csb_d))
        else $error("bus clock frequency mismatch");
    pci_base_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (state_q == ST_LOAD && host_s2_q) |=> base_q == $past(pci_s2_q))
        else $error("host mode base not from PCI sync");
    // Odd products lose their half kHz, so compare against the truncated value
    core_freq_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (cfg_ready_out && !core_cfg_err_out) |->
        64'(core_freq_khz_out) == ((64'(csb_freq_khz_out) * 64'(core_ratio_x2_out)) >> 1))
        else $error("core clock not bus clock times ratio");
    // First edge after release still shows reset values, so it is skipped
    ddr_half_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !$past(reset_in) |-> memory_bus_clock_out != $past(memory_bus_clock_out)
        && memory_bus_clock_n_out == !memory_bus_clock_out)
        else $error("memory clock not half rate");
    lb_div_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (!reset_in && local_bus_clock_ratio_reg_out == `SCRC_LBDIV_RST)[*3] |-> $changed(local_bus_clock_outputs))
        else $error("local bus clock not divided by two");
    unit_write_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $changed(unit_cfg_out) |-> $past(unit_cfg_wr_in))
        else $error("unit ratio changed without a write");
    third_tick_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (unit_cfg_out.eth == SCRC_THIRD)[*4] ##0 (ticks[0] && !unit_cfg_wr_in) |=>
        !ticks[0] ##1 !ticks[0] ##1 (ticks[0] || $past(unit_cfg_out.eth) != SCRC_THIRD))
        else $error("third ratio tick spacing wrong");
    pci_full_a: assert property (@(posedge clk_in) disable iff (reset_in)
        unit_cfg_out.pci_on[*3] |-> unit_clk_en_out[`SCRC_PCI_IDX])
        else $error("PCI clock not full rate");
    vco_div_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (cfg_ready_out && $past(cpll[`SCRC_VCO_MSB:`SCRC_VCO_LSB]) == `SCRC_VCO_SEL8) |-> vco_div_out == `SCRC_VCO_DIV8)
        else $error("VCO divider decode wrong");
    ratio_err_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (cfg_ready_out && !core_cfg_err_out) |-> core_ratio_x2_out inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8})
        else $error("core ratio outside legal set");
    cfg_err_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (cfg_ready_out && core_cfg_err_out) |-> core_freq_khz_out == 32'h0000_0000)
        else $error("reserved core code produced a frequency");

endmodule : scrc_top

// *** testbench/scrc_ref_model.sv ***
`timescale 1ns/100ps

module scrc_ref_model
    import scrc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // Frequency plan picked by the bench
    input  wire logic        sel_in,
    // Reference frequencies in kHz
    output logic [23:0]      primary_khz_out,
    output logic [23:0]      pci_sync_khz_out
);
    // plan moves only under reset
    // Straps must not move after release, the design samples them late
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            primary_khz_out  <= sel_in ? 24'h0061A8 : 24'h008235;
            pci_sync_khz_out <= sel_in ? 24'h008235 : 24'h01046A;
        end
    end
endmodule : scrc_ref_model

// *** testbench/tb_scrc_top.sv ***
`timescale 1ns/100ps
`include "scrc_defs.svh"

module tb_scrc_top
    import scrc_pkg::*;
;
    logic           clk_in, reset_in, hard, host, sel, uwr, lwr;
    logic [31:0]    rcw, seed, w;
    logic [23:0]    pkhz, skhz;
    logic [3:0]     lbf, rx2_o, vd_o, lbf_o;
    scrc_unit_cfg_t ucfg, ucfg_o, c;
    scrc_freq_t     csb_o, core_o;
    logic           cerr, verr, rdy, mem, mem_n, prev;
    logic [2:0]     lbc;
    logic [4:0]     en;
    int             n_fail, num_checks, cyc, g, k, i;
    int             lbtab[6] = '{0, 2, 4, 6, 8, 14};

    scrc_top i_dut (.clk_in(clk_in), .reset_in(reset_in), .reset_config_word_low_in(rcw),
        .hard_cfg_sel_in(hard), .pci_host_mode_in(host), .primary_clock_input_khz_in(pkhz),
        .pci_sync_khz_in(skhz), .unit_cfg_wr_in(uwr), .unit_cfg_in(ucfg), .lb_ratio_wr_in(lwr),
        .local_bus_divide_field_in(lbf), .csb_freq_khz_out(csb_o), .core_freq_khz_out(core_o),
        .core_ratio_x2_out(rx2_o), .vco_div_out(vd_o), .core_cfg_err_out(cerr),
        .vco_range_err_out(verr), .cfg_ready_out(rdy), .memory_bus_clock_out(mem),
        .memory_bus_clock_n_out(mem_n), .local_bus_clock_outputs(lbc), .unit_clk_en_out(en),
        .unit_cfg_out(ucfg_o), .local_bus_clock_ratio_reg_out(lbf_o));

    scrc_ref_model i_ref (.clk_in(clk_in), .reset_in(reset_in), .sel_in(sel),
        .primary_khz_out(pkhz), .pci_sync_khz_out(skhz));

    // Free-running 250 MHz clock
    always #2 clk_in = ~clk_in;

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    // Reset with new straps; checks reset state and readiness latency
    task automatic do_reset(input logic [31:0] wd, input logic h, input logic hm, input logic s);
        int j;
        @(posedge clk_in);
        reset_in <= 1'b1;
        rcw      <= wd;
        hard     <= h;
        host     <= hm;
        sel      <= s;
        repeat (12) @(posedge clk_in);
        check(csb_o | core_o | rdy | lbc | en, 0);
        check({mem, mem_n}, 2'h1);
        check(ucfg_o, {8'hFF, 1'h1});
        check(lbf_o, `SCRC_LBDIV_RST);
        reset_in <= 1'b0;
        for (j = 1; j < 12; j++)
        begin
            @(posedge clk_in);
            @(negedge clk_in);
            if (rdy === 1'b1)
                break;
        end
        check(j, 6);
    endtask : do_reset

    // Reference model of the derived frequencies and core decode
    task automatic exp_cfg(input logic [31:0] wd, input logic hm, input logic s);
        int base, csb, rx2, vd, core, err, rl;
        logic [6:0] f;
        base = hm ? (s ? 33333 : 66666) : (s ? 25000 : 33333);
        csb  = base * (1 + wd[31]) * wd[27:24];
        f    = wd[22:16];
        // Ratio and divider decode stand on their own; the error flag joins both
        rl   = !(f[4:1] < 1 || f[4:1] > 4 || (f[4:1] == 1 && !f[0]) || (f[4:1] == 4 && f[0]));
        err  = !rl || f[6:5] == 3 || (f[4:1] == 1 && f[6:5] == 0);
        rx2  = rl ? f[4:1] * 2 + f[0] : 0;
        vd   = (f[6:5] == 3) ? 0 : 2 << f[6:5];
        core = err ? 0 : csb * rx2 / 2;
        check(csb_o, csb);
        check(core_o, core);
        check(rx2_o, rx2);
        check(vd_o, vd);
        check(cerr, err);
        if (!err)
            check(verr, core * vd < 800000 || core * vd > 1600000);
    endtask : exp_cfg

    // Cycles between two events of one output, 0 when none seen
    task automatic gap_of(input int s, output int gp);
        int n;
        logic p, e;
        gp = 0;
        n  = -1;
        p  = lbc[0];
        for (int m = 0; m < 24 && gp == 0; m++)
        begin
            @(negedge clk_in);
            e = (s < 5) ? en[s] : (lbc[0] !== p);
            p = lbc[0];
            if (e === 1'b1)
            begin
                if (n >= 0)
                    gp = m - n;
                n = m;
            end
        end
    endtask : gap_of

    initial
    begin
        clk_in = 1'b0;
        reset_in = 1'b1;
        {hard, host, sel, uwr, lwr} = '0;
        rcw = '0;
        lbf = '0;
        ucfg = '0;
        {n_fail, num_checks, cyc} = '0;
        seed = 32'h753347DC;
        // hard-coded word in place of straps
        do_reset(32'hFFFF_FFFF, 1'b1, 1'b0, 1'b0);
        exp_cfg(`SCRC_RCW_HARD, 1'b0, 1'b0);
        // every core field code, random straps around it
        for (k = 0; k < 128; k++)
        begin
            seed = xs(seed);
            w = seed;
            w[22:16] = k[6:0];
            do_reset(w, 1'b0, w[0], w[1]);
            exp_cfg(w, w[0], w[1]);
        end
        // default divide counts and local bus half period
        for (k = 0; k < 6; k++)
        begin
            gap_of(k, g);
            check(g, k == 4 ? 1 : k == 5 ? 1 : 3);
        end
        // memory clock pair toggles every cycle
        prev = mem;
        repeat (8)
        begin
            @(negedge clk_in);
            check(mem, !prev);
            check(mem_n, !mem);
            prev = mem;
        end
        // software ratio changes, back to back writes included
        for (k = 0; k < 8; k++)
        begin
            seed = xs(seed);
            c = seed[8:0];
            @(posedge clk_in);
            ucfg <= c;
            uwr  <= 1'b1;
            if (k[0])
            begin
                @(posedge clk_in);
                ucfg <= ~c;
                c = ~c;
            end
            @(posedge clk_in);
            uwr <= 1'b0;
            @(negedge clk_in);
            check(ucfg_o, c);
            repeat (4) @(posedge clk_in);
            for (i = 0; i < 5; i++)
            begin
                gap_of(i, g);
                check(g, i == 4 ? c[0] : c[8 - 2 * i -: 2]);
            end
        end
        // local bus divider settings, zero stops the clocks
        for (k = 0; k < 6; k++)
        begin
            @(posedge clk_in);
            lbf <= lbtab[k][3:0];
            lwr <= 1'b1;
            @(posedge clk_in);
            lwr <= 1'b0;
            @(negedge clk_in);
            check(lbf_o, lbtab[k]);
            repeat (8) @(posedge clk_in);
            gap_of(5, g);
            check(g, lbtab[k] / 2);
            check(lbc, {3{lbc[0]}});
        end
        complete_run();
    end
endmodule : tb_scrc_top
